// ==== srfd_defines.vh ====
// constants for the serial receive frame delimiter
// included by the delimiter, the checker and the bench; definitions only
`ifndef SRFD_DEFINES_VH
`define SRFD_DEFINES_VH

// start modes
`define SRFD_SM_ANY     3'h0
`define SRFD_SM_BREAK   3'h1
`define SRFD_SM_IDLE    3'h2
`define SRFD_SM_CHAR    3'h3
`define SRFD_SM_SEQ     3'h4

// end criterion enable bit positions
`define SRFD_EB_MSGTMO  0
`define SRFD_EB_CDLY    1
`define SRFD_EB_FIXED   2
`define SRFD_EB_MAXCNT  3
`define SRFD_EB_LENFLD  4
`define SRFD_EB_ENDSEQ  5
`define SRFD_EB_W       6

// sticky error flag bit positions
`define SRFD_EF_DISCARD 0
`define SRFD_EF_RESP    1
`define SRFD_EF_OVF     2
`define SRFD_EF_LONG    3
`define SRFD_EF_W       4

// sequence slots and sequence sets
`define SRFD_SLOTS      5
`define SRFD_NSEQ       4

// largest frame, in characters
`define SRFD_MAX_FRAME  13'h1000
`define SRFD_LEN_W      13

// length field size codes
`define SRFD_LS_1       2'h0
`define SRFD_LS_2       2'h1
`define SRFD_LS_4       2'h2

// receiver states
`define SRFD_ST_HUNT    1'h0
`define SRFD_ST_RECV    1'h1

// reset values
`define SRFD_RST_LINE   1'h1
`define SRFD_RST_ERR    4'h0

`endif

// ==== srfd_sync.v ====
// two-stage synchroniser for levels arriving from outside the clock
// assumes an asynchronous active-high reset and a clock enable
`timescale 1ns/1ps
module srfd_sync
#(
  parameter       WIDTH   = 1,
  parameter [0:0] RST_VAL = 1'h0
)
(
  input  wire             clock_in,
  input  wire             sys_rst_in,
  input  wire             ce_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_q   <= {WIDTH{RST_VAL}};
      sync_out <= {WIDTH{RST_VAL}};
    end
    else if (ce_in)
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== srfd_seq_match.v ====
// right-aligned sequence comparator with don't-care slots
// slot 0 is compared with the newest character of the history
`timescale 1ns/1ps
module srfd_seq_match
#(
  parameter SLOTS = 5
)
(
  input  wire [8*SLOTS-1:0] hist_in,
  input  wire [SLOTS-1:0]   fill_in,
  input  wire [8*SLOTS-1:0] seq_in,
  input  wire [SLOTS-1:0]   care_in,
  input  wire [SLOTS-1:0]   used_in,
  output reg                hit_out
);

  integer i;

  // every used slot needs a character; cared slots must match it
  always @*
  begin
    hit_out = |used_in;
    for (i = 0; i < SLOTS; i = i + 1)
    begin
      if (used_in[i] && !fill_in[i])
        hit_out = 1'b0;
      if (used_in[i] && care_in[i] &&
          (hist_in[8*i +: 8] != seq_in[8*i +: 8]))
        hit_out = 1'b0;
    end
  end

endmodule

// ==== srfd_frame_delim.v ====
// receive frame delimiter: start detection, end detection, timeouts
// assumes a character receiver and bit-time tick on the same clock;
// the raw line level is a pin and is synchronised here
`timescale 1ns/1ps
`include "srfd_defines.vh"

// Overview of operation
// - default mode: first character opens frame
// - break mode: start only after line break
// - idle mode: start only after idle gap
// - start character opens frame when received
// - four start sequences with don't-care slots
// - end criteria evaluated only inside frame
// - message timeout timed from frame start
// - response timeout after transmit, flags error
// - character delay gap ends frame
// - fixed length ends; other end discards frame
// - after fixed length discard until start
// - maximum count ends; earlier end stays valid
// - after maximum count discard until start
// - length taken from field at offset
// - length field 1, 2 or 4 characters
// - trailing uncounted characters, 0 to 255
// - end sequence ends frame, data included
// - end sequence right-aligned in five slots
// - frame ring count, overwrite or reject
// - frames capped at 4 KB
module srfd_frame_delim
#(
  parameter TW    = 16,
  parameter NSEQ  = `SRFD_NSEQ,
  parameter SLOTS = `SRFD_SLOTS
)
(
  input  wire                    clock_in,
  input  wire                    sys_rst_in,
  input  wire                    ce_in,
  input  wire                    line_rx_in,
  input  wire                    char_valid_in,
  input  wire [7:0]              char_data_in,
  input  wire                    break_det_in,
  input  wire                    bit_tick_in,
  input  wire                    tx_done_in,
  input  wire [2:0]              start_mode_in,
  input  wire [7:0]              start_char_in,
  input  wire [TW-1:0]           idle_bits_in,
  input  wire [8*SLOTS*NSEQ-1:0] sseq_data_in,
  input  wire [SLOTS*NSEQ-1:0]   sseq_care_in,
  input  wire [SLOTS*NSEQ-1:0]   sseq_used_in,
  input  wire [`SRFD_EB_W-1:0]   end_en_in,
  input  wire [TW-1:0]           msg_tmo_in,
  input  wire [TW-1:0]           cdly_in,
  input  wire [12:0]             fix_len_in,
  input  wire [12:0]             max_len_in,
  input  wire [11:0]             len_off_in,
  input  wire [1:0]              len_size_in,
  input  wire [7:0]              len_trail_in,
  input  wire [8*SLOTS-1:0]      eseq_data_in,
  input  wire [SLOTS-1:0]        eseq_care_in,
  input  wire [SLOTS-1:0]        eseq_used_in,
  input  wire                    resp_en_in,
  input  wire [TW-1:0]           resp_tmo_in,
  input  wire [7:0]              frm_max_in,
  input  wire                    ovw_protect_in,
  input  wire                    frm_ack_in,
  input  wire [`SRFD_EF_W-1:0]   err_clr_in,
  output reg                     dat_valid_out,
  output reg  [7:0]              dat_out,
  output reg                     dat_first_out,
  output reg                     end_out,
  output reg                     end_ok_out,
  output reg                     drop_oldest_out,
  output reg  [7:0]              frm_cnt_out,
  output reg  [`SRFD_EF_W-1:0]   err_out,
  output reg                     busy_out
);

  localparam [TW-1:0] T_ONE = {{(TW-1){1'b0}}, 1'b1};
  localparam [12:0]   L_ONE = 13'h0001;

  wire              line_s;
  wire [NSEQ-1:0]   sseq_hit;
  wire              eseq_hit;

  reg               st_q;
  reg               armed_q;
  reg  [TW-1:0]     idle_cnt_q;
  reg  [TW-1:0]     cdly_cnt_q;
  reg  [TW-1:0]     msg_cnt_q;
  reg  [TW-1:0]     resp_cnt_q;
  reg               resp_run_q;
  reg  [12:0]       len_q;
  reg  [31:0]       fld_q;
  reg  [8*SLOTS-1:0] hist_q;
  reg  [SLOTS-1:0]  fill_q;

  reg  [8*SLOTS-1:0] hist_d;
  reg  [SLOTS-1:0]  fill_d;
  reg               start_hit;
  reg  [12:0]       len_d;
  reg  [12:0]       fld_end;
  reg               in_fld;
  reg  [31:0]       fld_d;
  reg  [33:0]       target;
  reg               fix_hit;
  reg               max_hit;
  reg               lfld_hit;
  reg               cdly_hit;
  reg               mtmo_hit;
  reg               long_hit;
  reg               any_end;
  reg               frm_good;

  srfd_sync
  #(
    .WIDTH   (1),
    .RST_VAL (`SRFD_RST_LINE)
  )
  u_line_sync
  (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .async_in   (line_rx_in),
    .sync_out   (line_s)
  );

  // history including the character of this cycle
  always @*
  begin
    hist_d = {hist_q[8*SLOTS-9:0], char_data_in};
    fill_d = {fill_q[SLOTS-2:0], 1'b1};
  end

  // each sequence is compared right-aligned with the history
  genvar g;
  generate
    for (g = 0; g < NSEQ; g = g + 1)
    begin : g_sseq
      srfd_seq_match
      #(
        .SLOTS (SLOTS)
      )
      u_sseq
      (
        .hist_in (hist_d),
        .fill_in (fill_d),
        .seq_in  (sseq_data_in[8*SLOTS*g +: 8*SLOTS]),
        .care_in (sseq_care_in[SLOTS*g +: SLOTS]),
        .used_in (sseq_used_in[SLOTS*g +: SLOTS]),
        .hit_out (sseq_hit[g])
      );
    end
  endgenerate

  // end sequence, newest character in slot 0
  srfd_seq_match
  #(
    .SLOTS (SLOTS)
  )
  u_eseq
  (
    .hist_in (hist_d),
    .fill_in (fill_d),
    .seq_in  (eseq_data_in),
    .care_in (eseq_care_in),
    .used_in (eseq_used_in),
    .hit_out (eseq_hit)
  );

  // start decision for a character arriving while hunting
  always @*
  begin
    case (start_mode_in)
      `SRFD_SM_ANY:   start_hit = 1'b1;
      // armed by break or idle gap
      `SRFD_SM_BREAK: start_hit = armed_q;
      `SRFD_SM_IDLE:  start_hit = armed_q;
      `SRFD_SM_CHAR:  start_hit = (char_data_in == start_char_in);
      `SRFD_SM_SEQ:   start_hit = |sseq_hit;
      default:        start_hit = 1'b0;
    endcase
    start_hit = start_hit & char_valid_in & (st_q == `SRFD_ST_HUNT);
  end

  // end criteria while receiving
  always @*
  begin
    len_d = len_q + L_ONE;
    // field end position for 1, 2 or 4 characters
    case (len_size_in)
      `SRFD_LS_2: fld_end = {1'b0, len_off_in} + 13'h0002;
      `SRFD_LS_4: fld_end = {1'b0, len_off_in} + 13'h0004;
      default:    fld_end = {1'b0, len_off_in} + 13'h0001;
    endcase
    // the character at len_q is inside the length field
    // a starting character sits at position 0
    in_fld = (st_q == `SRFD_ST_RECV) ?
             ((len_q >= {1'b0, len_off_in}) && (len_q < fld_end)) :
             (len_off_in == 12'h000);
    fld_d = in_fld ? {fld_q[23:0], char_data_in} : fld_q;
    target = {21'h00_0000, fld_end} + {2'h0, fld_d} +
             {26'h000_0000, len_trail_in};
    fix_hit  = 1'b0;
    max_hit  = 1'b0;
    lfld_hit = 1'b0;
    cdly_hit = 1'b0;
    mtmo_hit = 1'b0;
    long_hit = 1'b0;
    if (st_q == `SRFD_ST_RECV)
    begin
      if (char_valid_in)
      begin
        fix_hit  = end_en_in[`SRFD_EB_FIXED] && (len_d == fix_len_in);
        max_hit  = end_en_in[`SRFD_EB_MAXCNT] && (len_d == max_len_in);
        lfld_hit = end_en_in[`SRFD_EB_LENFLD] && (len_d >= fld_end) &&
                   ({21'h00_0000, len_d} == target);
        long_hit = (len_d == `SRFD_MAX_FRAME);
      end
      // gap exceeds limit in bit times
      cdly_hit = end_en_in[`SRFD_EB_CDLY] && !char_valid_in &&
                 bit_tick_in && (cdly_cnt_q >= cdly_in);
      mtmo_hit = end_en_in[`SRFD_EB_MSGTMO] && bit_tick_in &&
                 (msg_cnt_q + T_ONE >= msg_tmo_in);
    end
    any_end = fix_hit | max_hit | lfld_hit | cdly_hit | mtmo_hit |
              (end_en_in[`SRFD_EB_ENDSEQ] && eseq_hit && char_valid_in &&
               (st_q == `SRFD_ST_RECV));
    // with fixed length every other end is a failed frame
    frm_good = any_end &&
               (!end_en_in[`SRFD_EB_FIXED] || fix_hit);
  end

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_q            <= `SRFD_ST_HUNT;
      armed_q         <= 1'b0;
      idle_cnt_q      <= {TW{1'b0}};
      cdly_cnt_q      <= {TW{1'b0}};
      msg_cnt_q       <= {TW{1'b0}};
      resp_cnt_q      <= {TW{1'b0}};
      resp_run_q      <= 1'b0;
      len_q           <= 13'h0000;
      fld_q           <= 32'h0000_0000;
      hist_q          <= {(8*SLOTS){1'b0}};
      fill_q          <= {SLOTS{1'b0}};
      dat_valid_out   <= 1'b0;
      dat_out         <= 8'h00;
      dat_first_out   <= 1'b0;
      end_out         <= 1'b0;
      end_ok_out      <= 1'b0;
      drop_oldest_out <= 1'b0;
      frm_cnt_out     <= 8'h00;
      err_out         <= `SRFD_RST_ERR;
      busy_out        <= 1'b0;
    end
    else if (ce_in)
    begin
      dat_valid_out   <= 1'b0;
      dat_first_out   <= 1'b0;
      end_out         <= 1'b0;
      end_ok_out      <= 1'b0;
      drop_oldest_out <= 1'b0;

      // idle gap measured on the synchronised line level
      if (!line_s || char_valid_in)
        idle_cnt_q <= {TW{1'b0}};
      else if (bit_tick_in && (idle_cnt_q != {TW{1'b1}}))
        idle_cnt_q <= idle_cnt_q + T_ONE;

      if (st_q == `SRFD_ST_HUNT)
      begin
        if (start_hit)
          armed_q <= 1'b0;
        else if ((start_mode_in == `SRFD_SM_BREAK) && break_det_in)
          armed_q <= 1'b1;
        else if ((start_mode_in == `SRFD_SM_IDLE) &&
                 (idle_cnt_q >= idle_bits_in))
          armed_q <= 1'b1;
      end

      if (tx_done_in && resp_en_in)
      begin
        resp_run_q <= 1'b1;
        resp_cnt_q <= {TW{1'b0}};
      end
      else if (start_hit)
        resp_run_q <= 1'b0;
      else if (resp_run_q && bit_tick_in)
      begin
        if (resp_cnt_q + T_ONE >= resp_tmo_in)
          resp_run_q <= 1'b0;
        resp_cnt_q <= resp_cnt_q + T_ONE;
      end

      case (st_q)
        `SRFD_ST_HUNT:
        begin
          // characters before a start are dropped
          if (start_hit)
          begin
            st_q          <= `SRFD_ST_RECV;
            busy_out      <= 1'b1;
            dat_valid_out <= 1'b1;
            dat_first_out <= 1'b1;
            dat_out       <= char_data_in;
            len_q         <= L_ONE;
            fld_q         <= fld_d;
            cdly_cnt_q    <= {TW{1'b0}};
            msg_cnt_q     <= {TW{1'b0}};
            hist_q        <= {{(8*SLOTS-8){1'b0}}, char_data_in};
            fill_q        <= {{(SLOTS-1){1'b0}}, 1'b1};
          end
          else if (char_valid_in)
          begin
            hist_q <= hist_d;
            fill_q <= fill_d;
          end
        end
        `SRFD_ST_RECV:
        begin
          // message and character delay timers run only inside a frame
          if (bit_tick_in)
            msg_cnt_q <= msg_cnt_q + T_ONE;
          if (char_valid_in)
            cdly_cnt_q <= {TW{1'b0}};
          else if (bit_tick_in)
            cdly_cnt_q <= cdly_cnt_q + T_ONE;
          if (char_valid_in)
          begin
            dat_valid_out <= 1'b1;
            dat_out       <= char_data_in;
            len_q         <= len_d;
            fld_q         <= fld_d;
            hist_q        <= hist_d;
            fill_q        <= fill_d;
          end
          if (any_end || long_hit)
          begin
            st_q     <= `SRFD_ST_HUNT;
            busy_out <= 1'b0;
            end_out  <= 1'b1;
            fld_q    <= 32'h0000_0000;
            hist_q   <= {(8*SLOTS){1'b0}};
            fill_q   <= {SLOTS{1'b0}};
          end
        end
        default:
        begin
          st_q     <= `SRFD_ST_HUNT;
          busy_out <= 1'b0;
        end
      endcase

      if ((st_q == `SRFD_ST_RECV) && frm_good)
      begin
        if (frm_cnt_out >= frm_max_in)
        begin
          if (ovw_protect_in)
            frm_cnt_out <= frm_cnt_out - {7'h00, frm_ack_in};
          else
          begin
            end_ok_out      <= 1'b1;
            drop_oldest_out <= !frm_ack_in;
          end
        end
        else
        begin
          end_ok_out  <= 1'b1;
          frm_cnt_out <= frm_cnt_out + {7'h00, !frm_ack_in};
        end
      end
      else if (frm_ack_in && (frm_cnt_out != 8'h00))
        frm_cnt_out <= frm_cnt_out - 8'h01;

      // sticky flags; a new event wins over its clear
      err_out <= (err_out & ~err_clr_in) |
        ({{(`SRFD_EF_W-1){1'b0}}, (st_q == `SRFD_ST_RECV) &&
          any_end && !frm_good} << `SRFD_EF_DISCARD) |
        ({{(`SRFD_EF_W-1){1'b0}}, resp_run_q && !tx_done_in &&
          !start_hit && bit_tick_in &&
          (resp_cnt_q + T_ONE >= resp_tmo_in)} << `SRFD_EF_RESP) |
        ({{(`SRFD_EF_W-1){1'b0}}, (st_q == `SRFD_ST_RECV) && frm_good &&
          ovw_protect_in && (frm_cnt_out >= frm_max_in)} <<
          `SRFD_EF_OVF) |
        ({{(`SRFD_EF_W-1){1'b0}}, long_hit && !any_end} <<
          `SRFD_EF_LONG);
    end
  end

endmodule

// ==== srfd_properties.sv ====
// checker for the receive frame delimiter outputs
// bound to srfd_frame_delim; sees its ports only
`timescale 1ns/1ps
`include "srfd_defines.vh"
module srfd_properties
(
  input wire                  clock_in,
  input wire                  sys_rst_in,
  input wire                  ce_in,
  input wire                  char_valid_in,
  input wire [7:0]            char_data_in,
  input wire [2:0]            start_mode_in,
  input wire [7:0]            start_char_in,
  input wire [`SRFD_EB_W-1:0] end_en_in,
  input wire [`SRFD_EF_W-1:0] err_clr_in,
  input wire                  dat_valid_out,
  input wire [7:0]            dat_out,
  input wire                  dat_first_out,
  input wire                  end_out,
  input wire                  end_ok_out,
  input wire                  drop_oldest_out,
  input wire [`SRFD_EF_W-1:0] err_out,
  input wire                  busy_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_take;
    ce_in && char_valid_in;
  endsequence
  sequence s_hunt_take;
    !busy_out ##0 s_take;
  endsequence
  a_first_has_data: assert property (
    dat_first_out |-> dat_valid_out) else $error("first without data");
  a_any_opens: assert property (
    s_hunt_take ##0 (start_mode_in == `SRFD_SM_ANY) |=>
    dat_first_out && dat_out == $past(char_data_in))
    else $error("any char did not open frame");
  a_char_opens: assert property (
    s_hunt_take ##0 (start_mode_in == `SRFD_SM_CHAR) |=>
    dat_first_out == ($past(char_data_in) == $past(start_char_in)))
    else $error("start char decision wrong");
  a_frame_echo: assert property (
    busy_out ##0 s_take ##0 !end_en_in[`SRFD_EB_MSGTMO] |=>
    dat_valid_out && !dat_first_out && dat_out == $past(char_data_in))
    else $error("frame char not passed on");
  a_ok_with_end: assert property (
    end_ok_out |-> end_out) else $error("ok without end");
  a_end_to_hunt: assert property (
    end_out |-> !busy_out) else $error("still busy at end");
  a_drop_with_ok: assert property (
    drop_oldest_out |-> end_ok_out) else $error("drop without ok");
  a_bad_flagged: assert property (
    end_out && !end_ok_out |-> ##[0:1] (err_out != 4'h0))
    else $error("refused frame without flag");
  a_err_sticky: assert property (
    ce_in |=> (err_out & $past(err_out & ~err_clr_in)) ==
    $past(err_out & ~err_clr_in)) else $error("flag lost");
endmodule
bind srfd_frame_delim srfd_properties u_props (.*);

// ==== srfd_partner.sv ====
// remote serial partner: sends characters and line breaks
// assumes callers enter its tasks just after a clock edge
`timescale 1ns/1ps
module srfd_partner
(
  input  wire       clock_in,
  output reg        line_rx_out,
  output reg        char_valid_out,
  output reg  [7:0] char_data_out,
  output reg        break_det_out
);
  initial
  begin
    line_rx_out = 1'h1;
    char_valid_out = 1'h0;
    char_data_out = 8'h00;
    break_det_out = 1'h0;
  end
  // one character: line low for two clocks, then a one-clock valid strobe
  task send(input [7:0] d);
  begin
    @(posedge clock_in);
    #1 line_rx_out = 1'h0;
    repeat (2) @(posedge clock_in);
    #1 line_rx_out = 1'h1;
    char_valid_out = 1'h1;
    char_data_out = d;
    @(posedge clock_in);
    #1 char_valid_out = 1'h0;
    char_data_out = ~d;
  end
  endtask
  task brk;
  begin
    @(posedge clock_in);
    #1 break_det_out = 1'h1;
    @(posedge clock_in);
    #1 break_det_out = 1'h0;
  end
  endtask
endmodule

// ==== srfd_frame_delim_tb.sv ====
// self-checking bench for the receive frame delimiter
// assumes srfd_partner as the remote serial sender
`timescale 1ns/1ps
`include "srfd_defines.vh"
module srfd_frame_delim_tb;
  reg          clock_in;
  reg          sys_rst_in = 1'h1;
  reg          ce_in = 1'h1;
  reg          bit_tick_in = 1'h0;
  reg          tx_done_in = 1'h0;
  reg  [2:0]   start_mode_in = 3'h0;
  reg  [7:0]   start_char_in = 8'ha5;
  reg  [15:0]  idle_bits_in = 16'h0004;
  reg  [159:0] sseq_data_in = 160'h00_6800_0068;
  reg  [19:0]  sseq_care_in = 20'h0_0009;
  reg  [19:0]  sseq_used_in = 20'h0_000f;
  reg  [5:0]   end_en_in = 6'h02;
  reg  [15:0]  msg_tmo_in = 16'h0040;
  // cdly kept short for bench only
  reg  [15:0]  cdly_in = 16'h0003;
  reg  [12:0]  fix_len_in = 13'h0002;
  reg  [12:0]  max_len_in = 13'h0002;
  reg  [11:0]  len_off_in = 12'h001;
  reg  [1:0]   len_size_in = 2'h0;
  reg  [7:0]   len_trail_in = 8'h01;
  reg  [39:0]  eseq_data_in = 40'h00_0000_0d0a;
  reg  [4:0]   eseq_care_in = 5'h03;
  reg  [4:0]   eseq_used_in = 5'h03;
  reg          resp_en_in = 1'h0;
  reg  [15:0]  resp_tmo_in = 16'h0005;
  reg  [7:0]   frm_max_in = 8'hff;
  reg          ovw_protect_in = 1'h0;
  reg          frm_ack_in = 1'h0;
  reg  [3:0]   err_clr_in = 4'h0;
  wire         dat_valid_out;
  wire [7:0]   dat_out;
  wire         dat_first_out;
  wire         end_out;
  wire         end_ok_out;
  wire         drop_oldest_out;
  wire [7:0]   frm_cnt_out;
  wire [3:0]   err_out;
  wire         busy_out;
  wire         line_rx_in;
  wire         char_valid_in;
  wire [7:0]   char_data_in;
  wire         break_det_in;
  integer      failures = 0;
  integer      compares = 0;
  integer      cyc = 0;
  integer      nd, ne, nok, ndp;
  reg  [7:0]   fd, ld;
  srfd_frame_delim DUT (.*);
  srfd_partner p (
    .clock_in      (clock_in),
    .line_rx_out   (line_rx_in),
    .char_valid_out(char_valid_in),
    .char_data_out (char_data_in),
    .break_det_out (break_det_in)
  );
  initial
  begin
    clock_in = 1'h0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    bit_tick_in <= #1 ~bit_tick_in;
    cyc = cyc + 1;
    if (dat_valid_out === 1'h1) nd = nd + 1;
    if (dat_first_out === 1'h1) fd = dat_out;
    if (end_out === 1'h1) ne = ne + 1;
    if (end_out === 1'h1) ld = dat_out;
    if (end_ok_out === 1'h1) nok = nok + 1;
    if (drop_oldest_out === 1'h1) ndp = ndp + 1;
    if (cyc == 5000)
    begin
      failures = failures + 1;
      give_verdict;
    end
  end
  task give_verdict;
  begin
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task bad(input integer g, input integer e);
  begin
    failures = failures + 1;
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
  end
  endtask
  task chkn(input integer g, input integer e);
  begin
    compares = compares + 1;
    if (g !== e) bad(g, e);
  end
  endtask
  task chkv(input [7:0] g, input [7:0] e);
  begin
    compares = compares + 1;
    if (g !== e) bad(g, e);
  end
  endtask
  task idle(input integer n);
  begin
    repeat (n) @(posedge clock_in);
    #1;
  end
  endtask
  task clr(input [2:0] m, input [5:0] en);
  begin
    nd = 0;
    ne = 0;
    nok = 0;
    ndp = 0;
    fd = 8'h00;
    start_mode_in = m;
    end_en_in = en;
  end
  endtask
  task t_fixed;
  reg [7:0] c0;
  begin
    clr(`SRFD_SM_CHAR, 6'h04);
    start_char_in = 8'h5a;
    c0 = frm_cnt_out;
    p.send(8'h01);
    p.send(8'h5a);
    p.send(8'h22);
    p.send(8'h33);
    p.send(8'h44);
    idle(4);
    chkn(nd, 2);
    chkv(fd, 8'h5a);
    chkn(nok, 1);
    chkv(frm_cnt_out, c0 + 8'h01);
    frm_ack_in = 1'h1;
    idle(1);
    frm_ack_in = 1'h0;
    idle(1);
    chkv(frm_cnt_out, c0);
    $display("t_fixed done");
  end
  endtask
  task t_cdly;
  begin
    clr(`SRFD_SM_ANY, 6'h02);
    cdly_in = 16'h0004;
    p.send(8'h51);
    p.send(8'h52);
    chkn(ne, 0);
    idle(20);
    chkn(nok, 1);
    chkv(fd, 8'h51);
    chkn(nd, 2);
    $display("t_cdly done");
  end
  endtask
  task t_fix_err;
  begin
    clr(`SRFD_SM_ANY, 6'h06);
    fix_len_in = 13'h0004;
    p.send(8'h61);
    p.send(8'h62);
    idle(20);
    chkn(ne, 1);
    chkn(nok, 0);
    chkv({4'h0, err_out}, 8'h01);
    err_clr_in = 4'h1;
    idle(1);
    err_clr_in = 4'h0;
    idle(1);
    chkv({4'h0, err_out}, 8'h00);
    $display("t_fix_err done");
  end
  endtask
  task t_seq;
  begin
    clr(`SRFD_SM_SEQ, 6'h08);
    sseq_data_in = 160'h00_6800_0068;
    sseq_care_in = 20'h0_0009;
    sseq_used_in = 20'h0_000f;
    max_len_in = 13'h0002;
    p.send(8'h68);
    p.send(8'h68);
    p.send(8'h10);
    p.send(8'haa);
    p.send(8'h68);
    p.send(8'hbb);
    p.send(8'hcc);
    idle(20);
    chkv(fd, 8'h68);
    chkn(nd, 2);
    chkn(nok, 1);
    $display("t_seq done");
  end
  endtask
  task t_endseq;
  begin
    clr(`SRFD_SM_ANY, 6'h20);
    eseq_data_in = 40'h00_0000_0d0a;
    eseq_care_in = 5'h03;
    eseq_used_in = 5'h03;
    p.send(8'h31);
    p.send(8'h0d);
    p.send(8'h32);
    p.send(8'h0d);
    p.send(8'h0a);
    idle(3);
    chkn(ne, 1);
    chkn(nok, 1);
    chkn(nd, 5);
    chkv(ld, 8'h0a);
    $display("t_endseq done");
  end
  endtask
  task t_len;
  begin
    clr(`SRFD_SM_ANY, 6'h10);
    len_off_in = 12'h001;
    len_size_in = 2'h1;
    len_trail_in = 8'h01;
    p.send(8'h10);
    p.send(8'h00);
    p.send(8'h02);
    p.send(8'haa);
    p.send(8'hbb);
    chkn(ne, 0);
    p.send(8'hcc);
    idle(3);
    chkn(nok, 1);
    chkn(nd, 6);
    chkv(ld, 8'hcc);
    $display("t_len done");
  end
  endtask
  task t_break;
  begin
    clr(`SRFD_SM_BREAK, 6'h04);
    fix_len_in = 13'h0002;
    p.send(8'h77);
    p.brk;
    p.send(8'h78);
    p.send(8'h79);
    idle(3);
    chkn(nd, 2);
    chkv(fd, 8'h78);
    chkn(nok, 1);
    $display("t_break done");
  end
  endtask
  task t_msg;
  begin
    clr(`SRFD_SM_IDLE, 6'h01);
    idle_bits_in = 16'h0010;
    msg_tmo_in = 16'h0004;
    idle(40);
    p.send(8'h41);
    idle(12);
    chkn(nok, 1);
    p.send(8'h42);
    idle(4);
    chkn(nd, 1);
    chkv(fd, 8'h41);
    $display("t_msg done");
  end
  endtask
  task t_ring;
  reg [7:0] c0;
  begin
    clr(`SRFD_SM_ANY, 6'h04);
    fix_len_in = 13'h0002;
    ce_in = 1'h0;
    p.send(8'h55);
    ce_in = 1'h1;
    idle(2);
    chkn(nd, 0);
    c0 = frm_cnt_out;
    frm_max_in = c0;
    ovw_protect_in = 1'h1;
    p.send(8'h71);
    p.send(8'h72);
    idle(2);
    chkn(ne, 1);
    chkn(nok, 0);
    chkv(frm_cnt_out, c0);
    chkv({4'h0, err_out}, 8'h04);
    err_clr_in = 4'h4;
    idle(1);
    err_clr_in = 4'h0;
    ovw_protect_in = 1'h0;
    p.send(8'h73);
    p.send(8'h74);
    idle(2);
    chkn(nok, 1);
    chkn(ndp, 1);
    chkv(frm_cnt_out, c0);
    frm_max_in = 8'hff;
    $display("t_ring done");
  end
  endtask
  task t_resp;
  begin
    resp_en_in = 1'h1;
    resp_tmo_in = 16'h0004;
    tx_done_in = 1'h1;
    idle(1);
    tx_done_in = 1'h0;
    idle(30);
    chkv({4'h0, err_out}, 8'h02);
    err_clr_in = 4'h2;
    idle(1);
    err_clr_in = 4'h0;
    idle(1);
    chkv({4'h0, err_out}, 8'h00);
    $display("t_resp done");
  end
  endtask
  initial
  begin
    idle(5);
    sys_rst_in = 1'h0;
    idle(2);
    t_fixed;
    t_cdly;
    t_fix_err;
    t_seq;
    t_endseq;
    t_len;
    t_break;
    t_msg;
    t_ring;
    t_resp;
    give_verdict;
  end
endmodule
